// [logic/aco_pkg.sv]
// Package for the control-byte decoder and over-temperature comparator.
// Assumes a single 20 MHz system clock domain; serial pins are asynchronous.
package aco_pkg;
    localparam int unsigned CTRL_W = 8;
    localparam int unsigned CHAN_W = 3;
    localparam int unsigned RESULT_W = 10;
    localparam int unsigned UPPER_LSB = 3;
    localparam int unsigned BITCNT_W = 4;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
    localparam logic [CTRL_W-1:0] THRESH_RESET = 8'h99;
    localparam logic [BITCNT_W-1:0] BITS_PER_BYTE = 4'h8;
    localparam logic [BITCNT_W-1:0] BITCNT_RESET = 4'h0;
    localparam logic [BITCNT_W-1:0] BITCNT_STEP = 4'h1;
    localparam logic [CTRL_W-1:0] SHIFT_RESET = 8'h00;
    localparam int unsigned UPPER_W = CTRL_W - UPPER_LSB;
    localparam logic [UPPER_W-1:0] UPPER_ZERO = 5'h00;
    localparam int unsigned TOP_LSB = RESULT_W - CTRL_W;
    // Synchroniser depths and idle levels
    localparam int unsigned SYNC_DEPTH = 2;
    localparam int unsigned EDGE_DEPTH = 3;
    localparam logic [EDGE_DEPTH-1:0] EDGE_IDLE_LOW = 3'h0;
    localparam logic [SYNC_DEPTH-1:0] SYNC_IDLE_LOW = 2'h0;
    localparam logic [SYNC_DEPTH-1:0] SYNC_IDLE_HIGH = 2'h3;
    localparam logic BUSY_IDLE = 1'h0;
    localparam logic ALARM_IDLE = 1'h1;
    localparam logic ALARM_ACTIVE = 1'h0;
    // Channel codes
    localparam logic [CHAN_W-1:0] CHAN_TEMP = 3'h0;
    localparam logic [CHAN_W-1:0] CHAN_IN1 = 3'h1;
    localparam logic [CHAN_W-1:0] CHAN_IN2 = 3'h2;
    localparam logic [CHAN_W-1:0] CHAN_IN3 = 3'h3;
    localparam logic [CHAN_W-1:0] CHAN_IN4 = 3'h4;
    localparam logic [CHAN_W-1:0] CHAN_BANDGAP = 3'h7;
    localparam int unsigned MUX_W = 6;
    localparam logic [MUX_W-1:0] MUX_NONE = 6'h00;
    localparam logic [MUX_W-1:0] MUX_TEMP = 6'h01;
    localparam logic [MUX_W-1:0] MUX_IN1 = 6'h02;
    localparam logic [MUX_W-1:0] MUX_IN2 = 6'h04;
    localparam logic [MUX_W-1:0] MUX_IN3 = 6'h08;
    localparam logic [MUX_W-1:0] MUX_IN4 = 6'h10;
    localparam logic [MUX_W-1:0] MUX_BANDGAP = 6'h20;
endpackage

// [logic/aco_ctrl.sv]
// Control-byte decoder, channel select and over-temperature alarm.
// Assumes serial pins arrive from a host clock domain and are sampled here;
// conversion start/end strobes and results come from logic on clk_i.
// Function
// RULE_01 - One control byte loads exactly one register
// RULE_02 - Upper five zero: low three to channel
// RULE_03 - Three-bit channel selects next conversion input
// RULE_04 - Code zero selects temperature sensor
// RULE_05 - Decode codes 1-4 inputs, 7 bandgap
// RULE_06 - Channel resets to zero
// RULE_07 - Any upper bit set: byte to threshold
// RULE_08 - Compare result top eight bits with threshold
// RULE_09 - Result above threshold drives alarm low
// RULE_10 - Rising direction edge releases alarm
// RULE_11 - Later lower temperature releases alarm
// RULE_12 - Host threshold code is degrees plus 103
// RULE_13 - Threshold resets to decimal 153
// RULE_14 - Host threshold range -95 to +152
// RULE_15 - Host waits acquisition time between conversions
// RULE_16 - Direction high read, low write
// RULE_17 - Sample data on serial clock rise
// RULE_18 - Alarm release needs chip select low
// RULE_19 - Busy high throughout any conversion
// RULE_20 - Byte shifted MSB first while selected
`timescale 1ns/1ps
module aco_ctrl
    import aco_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic rd_wr_i,
    input wire logic din_i,
    input wire logic conv_start_i,
    input wire logic conv_done_i,
    input wire logic [RESULT_W-1:0] conv_result_i,
    output logic [CHAN_W-1:0] channel_select_o,
    output logic [MUX_W-1:0] mux_sel_o,
    output logic [CTRL_W-1:0] overtemp_threshold_o,
    output logic overtemp_alarm_n_o,
    output logic busy_o
);
    typedef enum logic [1:0] {ACO_IDLE, ACO_TEMP, ACO_VOLT} aco_conv_t;

    // Pin synchronisers; the third sclk and rd_wr stage only feeds edge detection
    logic [EDGE_DEPTH-1:0] sclk_sync_q;
    logic [SYNC_DEPTH-1:0] cs_sync_q;
    logic [EDGE_DEPTH-1:0] rw_sync_q;
    logic [SYNC_DEPTH-1:0] din_sync_q;

    // Serial write shifter
    logic [CTRL_W-1:0] shift_q;
    logic [BITCNT_W-1:0] bit_cnt_q;

    // Programmable registers
    logic [CHAN_W-1:0] chan_q;
    logic [CTRL_W-1:0] thresh_q;

    // Conversion tracking and outputs
    aco_conv_t conv_q;
    logic [MUX_W-1:0] mux_q;
    logic busy_q;
    logic alarm_n_q;

    // Decoded events
    logic sclk_rise;
    logic rw_rise;
    logic cs_low;
    logic write_mode;
    logic [CTRL_W-1:0] byte_d;
    logic byte_done;
    logic chan_byte;
    logic temp_done;
    logic [CTRL_W-1:0] result_top;
    logic over_limit;
    logic under_limit;
    logic read_end;

    // Channel code to one-hot mux select; undefined codes select nothing
    function automatic logic [MUX_W-1:0] aco_decode(input logic [CHAN_W-1:0] code);
        case (code)
            CHAN_TEMP: aco_decode = MUX_TEMP;
            CHAN_IN1: aco_decode = MUX_IN1;
            CHAN_IN2: aco_decode = MUX_IN2;
            CHAN_IN3: aco_decode = MUX_IN3;
            CHAN_IN4: aco_decode = MUX_IN4;
            CHAN_BANDGAP: aco_decode = MUX_BANDGAP;
            default: aco_decode = MUX_NONE;
        endcase
    endfunction

    // Rising edge seen between the last two synchroniser stages
    function automatic logic aco_rise(input logic [EDGE_DEPTH-1:0] sync);
        aco_rise = sync[EDGE_DEPTH-2] & ~sync[EDGE_DEPTH-1];
    endfunction

    // A byte with its five upper bits clear is a channel write
    function automatic logic aco_is_chan(input logic [CTRL_W-1:0] ctrl);
        aco_is_chan = (ctrl[CTRL_W-1:UPPER_LSB] == UPPER_ZERO);
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sclk_sync_q <= EDGE_IDLE_LOW;
        end
        else
        begin
            sclk_sync_q <= {sclk_sync_q[EDGE_DEPTH-2:0], sclk_i};
        end
    end

    // Chip select resets to its idle level so no false selection follows reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cs_sync_q <= SYNC_IDLE_HIGH;
        end
        else
        begin
            cs_sync_q <= {cs_sync_q[SYNC_DEPTH-2:0], cs_n_i};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rw_sync_q <= EDGE_IDLE_LOW;
        end
        else
        begin
            rw_sync_q <= {rw_sync_q[EDGE_DEPTH-2:0], rd_wr_i};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            din_sync_q <= SYNC_IDLE_LOW;
        end
        else
        begin
            din_sync_q <= {din_sync_q[SYNC_DEPTH-2:0], din_i};
        end
    end

    assign sclk_rise = aco_rise(sclk_sync_q);
    assign rw_rise = aco_rise(rw_sync_q);
    assign cs_low = ~cs_sync_q[SYNC_DEPTH-1];
    assign write_mode = cs_low && !rw_sync_q[SYNC_DEPTH-1];
    assign byte_d = {shift_q[CTRL_W-2:0], din_sync_q[SYNC_DEPTH-1]};
    assign byte_done = sclk_rise && write_mode && (bit_cnt_q == BITS_PER_BYTE - BITCNT_STEP);
    assign chan_byte = aco_is_chan(byte_d);
    assign temp_done = (conv_q == ACO_TEMP) && conv_done_i;
    assign result_top = conv_result_i[RESULT_W-1:TOP_LSB];
    assign over_limit = temp_done && (result_top > thresh_q);
    assign under_limit = temp_done && (result_top < thresh_q);
    assign read_end = rw_rise && cs_low;

    // A deselect or a read abandons a partial byte
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !write_mode)
        begin
            shift_q <= SHIFT_RESET;
        end
        else if (sclk_rise) // [RULE_17] [RULE_20]
        begin
            shift_q <= byte_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !write_mode) // [RULE_16]
        begin
            bit_cnt_q <= BITCNT_RESET;
        end
        else if (byte_done)
        begin
            bit_cnt_q <= BITCNT_RESET;
        end
        else if (sclk_rise)
        begin
            bit_cnt_q <= bit_cnt_q + BITCNT_STEP;
        end
    end

    // Byte steering: a finished byte lands in exactly one register
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            chan_q <= CHAN_RESET; // [RULE_06]
        end
        else if (byte_done && chan_byte) // [RULE_01]
        begin
            chan_q <= byte_d[CHAN_W-1:0]; // [RULE_02]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            thresh_q <= THRESH_RESET; // [RULE_13]
        end
        else if (byte_done && !chan_byte) // [RULE_01]
        begin
            thresh_q <= byte_d; // [RULE_07]
        end
    end

    // Mux select latched while idle, so a mid-conversion channel write waits
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            mux_q <= MUX_TEMP;
        end
        else if (conv_q == ACO_IDLE)
        begin
            mux_q <= aco_decode(chan_q); // [RULE_03] [RULE_05]
        end
    end

    // Conversion kind fixed at start: only channel zero counts as temperature
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            conv_q <= ACO_IDLE;
        end
        else
        begin
            case (conv_q)
                ACO_IDLE:
                begin
                    if (conv_start_i)
                    begin
                        conv_q <= (chan_q == CHAN_TEMP) ? ACO_TEMP : ACO_VOLT; // [RULE_04]
                    end
                end
                ACO_TEMP, ACO_VOLT:
                begin
                    if (conv_done_i)
                    begin
                        conv_q <= ACO_IDLE;
                    end
                end
                default:
                begin
                    conv_q <= ACO_IDLE;
                end
            endcase
        end
    end

    // Busy moves on the same edges as the conversion state
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            busy_q <= BUSY_IDLE;
        end
        else if (conv_q == ACO_IDLE)
        begin
            busy_q <= conv_start_i; // [RULE_19]
        end
        else
        begin
            busy_q <= !conv_done_i;
        end
    end

    // A result above the threshold wins over a release in the same cycle;
    // an equal result keeps the alarm but must not swallow a release
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            alarm_n_q <= ALARM_IDLE;
        end
        else if (over_limit) // [RULE_08]
        begin
            alarm_n_q <= ALARM_ACTIVE; // [RULE_09]
        end
        else if (under_limit)
        begin
            alarm_n_q <= ALARM_IDLE; // [RULE_11]
        end
        else if (read_end)
        begin
            alarm_n_q <= ALARM_IDLE; // [RULE_10] [RULE_18]
        end
    end

    assign channel_select_o = chan_q;
    assign mux_sel_o = mux_q;
    assign overtemp_threshold_o = thresh_q;
    assign overtemp_alarm_n_o = alarm_n_q;
    assign busy_o = busy_q;
endmodule

// [testbench/aco_host.sv]
// Host model driving the serial port pins.
// Assumes each call starts 5 ns after a clock edge.
`timescale 1ns/1ps
module aco_host (
    output logic sclk_o,
    output logic cs_n_o,
    output logic rd_wr_o,
    output logic din_o
);
    initial {sclk_o, cs_n_o, rd_wr_o, din_o} = 4'h4;
    task automatic wr_byte(input logic [7:0] b);
        {cs_n_o, rd_wr_o} = 2'h0;
        for (int i = 7; i >= 0; i--)
        begin
            din_o = b[i];
            #200 sclk_o = 1'h1;
            #200 sclk_o = 1'h0;
        end
        #200 cs_n_o = 1'h1;
        din_o = ~din_o; // No pull on a released line
        #200;
    endtask
    task automatic rd_end(input logic c);
        cs_n_o = c;
        #200 rd_wr_o = 1'h1;
        #200 {rd_wr_o, cs_n_o} = 2'h1;
        #200;
    endtask
endmodule

// [testbench/aco_ctrl_chk.sv]
// Port checker for aco_ctrl.
// Assumes one clk_i domain, sync reset.
`timescale 1ns/1ps
module aco_chk (
    input logic clk_i,
    input logic sys_rst_i,
    input logic conv_start_i,
    input logic conv_done_i,
    input logic [9:0] conv_result_i,
    input logic [2:0] channel_select_o,
    input logic [5:0] mux_sel_o,
    input logic [7:0] overtemp_threshold_o,
    input logic overtemp_alarm_n_o,
    input logic busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic tmp_q;
    wire [7:0] top = conv_result_i[9:2];
    wire [7:0] thr = overtemp_threshold_o;
    always_ff @(posedge clk_i) if (conv_start_i && !busy_o) tmp_q <= channel_select_o == 3'h0;
    sequence s_tdone;
        busy_o && conv_done_i && tmp_q;
    endsequence
    a_busy_rise: assert property (conv_start_i && !busy_o |=> busy_o) else $error("busy");
    a_busy_fall: assert property (busy_o && conv_done_i |=> !busy_o) else $error("busy");
    a_alarm_set: assert property (s_tdone ##0 top > thr |=> !overtemp_alarm_n_o) else $error("alarm");
    a_alarm_clr: assert property (s_tdone ##0 top < thr |=> overtemp_alarm_n_o) else $error("alarm");
    a_reset_vals: assert property (disable iff (1'h0) sys_rst_i |=>
        channel_select_o == 3'h0 && thr == 8'h99 && overtemp_alarm_n_o && !busy_o) else $error("reset");
    a_one_reg: assert property ($changed(thr) |-> $stable(channel_select_o)) else $error("regs");
    a_mux_hold: assert property (busy_o && $past(busy_o) |-> $stable(mux_sel_o)) else $error("mux");
    a_mux_temp: assert property ((!busy_o && channel_select_o == 3'h0) [*2] |-> mux_sel_o == 6'h01)
        else $error("mux");
endmodule
bind aco_ctrl aco_chk u_chk (.*);

// [testbench/tb_top.sv]
// Bench: host model writes bytes, conversions driven here.
// Assumes aco_ctrl, aco_host and the bound checker.
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'h0, sys_rst_i = 1'h1, st = 1'h0, dn = 1'h0, a_exp = 1'h1;
    logic sclk, cs_n, rw, din, alm, busy;
    logic [9:0] res = 10'h000;
    logic [7:0] thr, t_exp;
    logic [5:0] mux;
    logic [2:0] ch;
    int fails = 0, n_tests = 0, dg;
    aco_ctrl u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .rd_wr_i(rw),
        .din_i(din), .conv_start_i(st), .conv_done_i(dn), .conv_result_i(res), .channel_select_o(ch),
        .mux_sel_o(mux), .overtemp_threshold_o(thr), .overtemp_alarm_n_o(alm), .busy_o(busy));
    aco_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .rd_wr_o(rw), .din_o(din));
    initial forever #25 clk_i = ~clk_i;
    function automatic logic al_of(input logic a, input logic [7:0] top);
        return (top > t_exp) ? 1'h0 : (top < t_exp) ? 1'h1 : a;
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic conv(input logic [7:0] top, input logic tmp);
        @(posedge clk_i);
        #5 st = 1'h1;
        res = {top, 2'($urandom)};
        @(posedge clk_i);
        #5 st = 1'h0;
        chk(busy, 8'h01);
        repeat (3) @(posedge clk_i);
        #5 dn = 1'h1;
        @(posedge clk_i);
        #5 dn = 1'h0;
        repeat (2) @(posedge clk_i);
        if (tmp) a_exp = al_of(a_exp, top);
        #5 chk(alm, a_exp);
        chk(busy, 8'h00);
        // Return off the edge so the host model never drives on it
        repeat (8) @(posedge clk_i);
        #5;
    endtask
    initial
    begin
        void'($urandom(32'hf419));
        repeat (3) @(posedge clk_i);
        #5 sys_rst_i = 1'h0;
        chk(ch, 8'h00);
        chk(thr, 8'h99);
        for (int c = 7; c >= 0; c--)
        begin
            u_host.wr_byte(8'(c));
            chk(ch, 8'(c));
            chk(mux, (c == 7) ? 8'h20 : (c < 5) ? 8'h01 << c : 8'h00);
        end
        for (int k = 0; k < 6; k++)
        begin
            dg = (k == 0) ? -95 : (k == 1) ? 152 : int'($urandom_range(247)) - 95;
            t_exp = 8'(dg + 103);
            u_host.wr_byte(t_exp);
            chk(thr, t_exp);
            chk(ch, 8'h00);
            for (int j = 0; j < 4; j++)
                conv((j == 3) ? 8'($urandom) : t_exp + 8'(1 - j), 1'h1);
            conv(8'hff, 1'h1);
            u_host.rd_end(k[0]);
            if (!k[0]) a_exp = 1'h1;
            chk(alm, a_exp);
        end
        // Release first, so a voltage result that wrongly sets the alarm shows
        u_host.rd_end(1'h0);
        a_exp = 1'h1;
        chk(alm, a_exp);
        u_host.wr_byte(8'h01);
        conv(8'hff, 1'h0);
        test_done();
    end
endmodule
